// ---- shared/crm_pkg.sv ----
/*
  Constants shared by the clock and reset manager: register indices,
  field positions, reset values, sequencer states and cycle counts.
  Assumes a 100 MHz system clock.
*/
package crm_pkg;
  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_MAIN_CLK  = 8'h38;
  localparam logic [7:0] IDX_RC_TRIM   = 8'h39;
  localparam logic [7:0] IDX_SYS_INTEG = 8'h3A;
  // Field positions
  localparam int unsigned BIT_SLOW_MODE = 0;
  localparam int unsigned BIT_CLK_OUT   = 1;
  localparam int unsigned BIT_LOCKED    = 3;
  // Values after reset
  localparam logic [7:0] RST_MAIN_CLK = 8'h00;
  localparam logic [7:0] RST_RC_TRIM  = 8'hFF;
  // Clock arithmetic
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SRC_PERIOD_NS = 1000;
  localparam int unsigned PLL_X4_DIV = SRC_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int unsigned PLL_X8_DIV = SRC_PERIOD_NS / (8 * CLK_PERIOD_NS);
  localparam logic [7:0]  RC_DIV_MIN = 8'h24;
  localparam logic [4:0]  SLOW_DIV_LAST = 5'h1F;
  // Reset sequence
  localparam logic [8:0]  DELAY_LAST = 9'h0FF;
  localparam logic [8:0]  FETCH_LAST = 9'h001;
  localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    CRM_ACTIVE = 5'h01,
    CRM_DELAY  = 5'h02,
    CRM_PWAIT  = 5'h04,
    CRM_FETCH  = 5'h08,
    CRM_RUN    = 5'h10
  } crm_seq_e;
endpackage

// ---- shared/crm_rst_if.sv ----
/*
  Link between the clock core and the reset sequencer.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface crm_rst_if;
  logic        base_tick;
  logic        cpu_tick;
  logic        pll_need;
  logic        pll_ready;
  logic        low_voltage_detector;
  logic        wdg;
  logic        pin_in;
  logic        pin_oe;
  logic        core_rst_n;
  logic        seq_active;
  logic        fetch;
  logic [15:0] fetch_addr;
  modport seq (input base_tick, cpu_tick, pll_need, pll_ready, low_voltage_detector, wdg,
               pin_in, output pin_oe, core_rst_n, seq_active, fetch,
               fetch_addr);
  modport ctl (output base_tick, cpu_tick, pll_need, pll_ready, low_voltage_detector, wdg,
               pin_in, input pin_oe, core_rst_n, seq_active, fetch,
               fetch_addr);
endinterface

// ---- hw/crm_reset_seq.sv ----
/*
  Reset sequencer: active phase, 256-tick delay, optional PLL wait,
  two-tick vector fetch. Assumes an open-drain reset pin resolved
  outside, with a weak pull-up.
*/
`timescale 1ns/1ps
module crm_reset_seq #(
  parameter int unsigned WDG_PULSE_CYC = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Link to the clock core
  crm_rst_if.seq   rif
);
  crm_pkg::crm_seq_e state_ff, nxt_state;
  logic [8:0]  cnt_ff, nxt_cnt;
  logic [7:0]  wdg_ff, nxt_wdg;
  logic        oe_ff, nxt_oe, oe_hold_ff, hit_ff, nxt_hit;
  logic [15:0] addr_ff, nxt_addr;
  logic        seq_arst_n;

  // Pin low from outside resets without a clock; own drive is masked
  // one cycle longer so the pin's rise cannot glitch the detector
  assign seq_arst_n = arst_n_in & (rif.pin_in | oe_ff | oe_hold_ff);

  // Sticky external hit, cleared once the sequencer holds it
  always_comb begin
    nxt_hit = hit_ff & (state_ff != crm_pkg::CRM_ACTIVE);
  end
  always_ff @(posedge clk_in or negedge seq_arst_n) begin
    if (!seq_arst_n) hit_ff <= 1'b1;
    else hit_ff <= nxt_hit;
  end

  // Phase walk
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_wdg   = (wdg_ff != 8'h00) ? wdg_ff - 8'h01 : 8'h00;
    unique case (state_ff)
      crm_pkg::CRM_ACTIVE: begin
        if (!hit_ff && !rif.low_voltage_detector && wdg_ff == 8'h00) begin
          nxt_state = crm_pkg::CRM_DELAY;
          nxt_cnt   = 9'h000;
        end
      end
      crm_pkg::CRM_DELAY: begin
        if (rif.base_tick) begin
          nxt_cnt = cnt_ff + 9'h001;
          if (cnt_ff == crm_pkg::DELAY_LAST) begin
            nxt_cnt   = 9'h000;
            nxt_state = rif.pll_need ? crm_pkg::CRM_PWAIT
                                     : crm_pkg::CRM_FETCH;
          end
        end
      end
      crm_pkg::CRM_PWAIT: begin
        if (rif.pll_ready) nxt_state = crm_pkg::CRM_FETCH;
      end
      crm_pkg::CRM_FETCH: begin
        if (rif.cpu_tick) begin
          nxt_cnt = cnt_ff + 9'h001;
          if (cnt_ff == crm_pkg::FETCH_LAST) begin
            nxt_state = crm_pkg::CRM_RUN;
          end
        end
      end
      crm_pkg::CRM_RUN: nxt_state = crm_pkg::CRM_RUN;
    endcase
    // Internal sources restart the sequence from any phase
    if (rif.wdg) begin
      nxt_wdg   = 8'(WDG_PULSE_CYC);
      nxt_state = crm_pkg::CRM_ACTIVE;
    end
    if (rif.low_voltage_detector) nxt_state = crm_pkg::CRM_ACTIVE;
    // An outside pin hit restarts from any phase, RUN included, or the
    // sticky hit would never clear and the core would stay in reset
    if (hit_ff) nxt_state = crm_pkg::CRM_ACTIVE;
    nxt_oe = (nxt_state == crm_pkg::CRM_DELAY) ||
             (nxt_state == crm_pkg::CRM_ACTIVE &&
              (rif.low_voltage_detector || nxt_wdg != 8'h00));
    nxt_addr = {crm_pkg::RESET_VECTOR[15:1], nxt_cnt[0]};
  end

  // Registers of the sequencer
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff   <= crm_pkg::CRM_ACTIVE;
      cnt_ff     <= 9'h000;
      wdg_ff     <= 8'h00;
      oe_ff      <= 1'b0;
      oe_hold_ff <= 1'b0;
      addr_ff    <= crm_pkg::RESET_VECTOR;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      wdg_ff     <= nxt_wdg;
      oe_ff      <= nxt_oe;
      oe_hold_ff <= oe_ff;
      addr_ff    <= nxt_addr;
    end
  end

  assign rif.pin_oe     = oe_ff;
  assign rif.core_rst_n = (state_ff == crm_pkg::CRM_RUN) & ~hit_ff;
  assign rif.seq_active = (state_ff == crm_pkg::CRM_ACTIVE);
  assign rif.fetch      = (state_ff == crm_pkg::CRM_FETCH);
  assign rif.fetch_addr = addr_ff;

  // Checks on the sequence
  sequence s_fetch_lo;
    rif.fetch && rif.fetch_addr == crm_pkg::RESET_VECTOR && rif.cpu_tick;
  endsequence
  a_delay_pin_low: assert property (@(posedge clk_in) disable iff
    (!arst_n_in) state_ff == crm_pkg::CRM_DELAY |-> rif.pin_oe)
    else $error("pin not driven low during delay");
  a_delay_ends: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (state_ff == crm_pkg::CRM_DELAY && rif.base_tick && !rif.low_voltage_detector &&
     !rif.wdg && cnt_ff == 9'h0FF) |=> state_ff != crm_pkg::CRM_DELAY &&
     !rif.pin_oe)
    else $error("delay did not end after 256 ticks");
  a_vector_order: assert property (@(posedge clk_in) disable iff
    (!arst_n_in || rif.low_voltage_detector || rif.wdg) s_fetch_lo |=>
    rif.fetch && rif.fetch_addr[0])
    else $error("vector fetch not two ticks in order");
  a_ext_async: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (!rif.pin_in && !oe_ff && !oe_hold_ff) |-> !rif.core_rst_n)
    else $error("external reset not seen");
  a_wdg_pulse: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    rif.wdg |=> rif.pin_oe [*2])
    else $error("watchdog pulse too short");
endmodule // crm_reset_seq

// ---- hw/crm_top.sv ----
/*
  Clock and reset manager: oscillator selection, PLL, slow mode, clock
  output and reset sequencing behind an Avalon-MM slave.
  Assumes all inputs synchronous to clk_in; the reset pin is resolved
  outside from its output enable with a weak pull-up.
*/
`timescale 1ns/1ps
module crm_top #(
  parameter int unsigned PLL_STARTUP_CYC = 2000,
  parameter int unsigned WDG_PULSE_CYC   = 4
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Option bits and clock source
  input  wire logic        opt_rc_en_in,
  input  wire logic        opt_pll_en_in,
  input  wire logic        opt_pll_x8_in,
  input  wire logic        ext_clk_in,
  input  wire logic        halt_wakeup_in,
  // Reset sources and reset pin
  input  wire logic        low_voltage_detector_in,
  input  wire logic        wdg_underflow_in,
  input  wire logic        rst_pin_in,
  output logic             rst_pin_out,
  output logic             rst_pin_oe_out,
  // Clock results
  output logic             osc_tick_out,
  output logic             cpu_tick_out,
  output logic [7:0]       rc_trim_value_out,
  output logic             clock_output_pin_out,
  output logic             clock_output_enable_out,
  output logic             pll_locked_out,
  // Core reset and vector fetch
  output logic             core_rst_n_out,
  output logic             vector_fetch_out,
  output logic [15:0]      vector_addr_out
);
  crm_rst_if rif ();

  logic       ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] mcc_ff, nxt_mcc;
  logic [7:0] trim_ff, nxt_trim;
  logic [7:0] rc_cnt_ff, nxt_rc_cnt;
  logic [4:0] pll_cnt_ff, nxt_pll_cnt;
  logic [4:0] slow_ff, nxt_slow;
  logic [31:0] start_ff, nxt_start;
  logic       locked_ff, nxt_locked;
  logic       ext_d_ff, mco_ff, nxt_mco;
  logic       rc_tick, ext_tick, pll_tick, base_tick, osc_tick, cpu_tick;
  logic [7:0] idx;
  logic       req, wr_go;

  // RC period shrinks as trim falls; 80h gives the nominal 1 MHz
  function automatic logic [7:0] rc_period(input logic [7:0] t);
    rc_period = crm_pkg::RC_DIV_MIN + {1'b0, t[7:1]};
  endfunction

  // Index equality against a register's printed offset
  function automatic logic hit_idx(input logic [7:0] a,
                                   input logic [7:0] b);
    hit_idx = (a == b);
  endfunction

  // Bus request with one wait cycle; data taken on the second edge
  assign idx   = avs_address_in[9:2];
  assign req   = avs_read_in | avs_write_in;
  assign wr_go = avs_write_in & ack_ff & avs_byteenable_in[0];
  assign avs_waitrequest_out = req & ~ack_ff;
  assign avs_readdata_out    = rdata_ff;

  always_comb begin
    nxt_ack   = req & ~ack_ff;
    nxt_rdata = rdata_ff;
    if (avs_read_in && !ack_ff) begin
      nxt_rdata = 32'h0000_0000; // Unmapped reads return zero
      if (hit_idx(idx, crm_pkg::IDX_MAIN_CLK))
        nxt_rdata[1:0] = mcc_ff;
      if (hit_idx(idx, crm_pkg::IDX_RC_TRIM))
        nxt_rdata[7:0] = trim_ff;
      if (hit_idx(idx, crm_pkg::IDX_SYS_INTEG))
        nxt_rdata[crm_pkg::BIT_LOCKED] = locked_ff;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // Control registers; every device reset restores defaults, so any
  // trim loaded before is lost and must be written again
  always_comb begin
    nxt_mcc  = mcc_ff;
    nxt_trim = trim_ff;
    if (!rif.core_rst_n) begin
      nxt_mcc  = crm_pkg::RST_MAIN_CLK[1:0];
      nxt_trim = crm_pkg::RST_RC_TRIM;
    end else if (wr_go) begin
      if (hit_idx(idx, crm_pkg::IDX_MAIN_CLK))
        nxt_mcc = avs_writedata_in[1:0]; // Reserved bits not stored
      if (hit_idx(idx, crm_pkg::IDX_RC_TRIM))
        nxt_trim = avs_writedata_in[7:0];
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mcc_ff  <= crm_pkg::RST_MAIN_CLK[1:0];
      trim_ff <= crm_pkg::RST_RC_TRIM;
    end else begin
      mcc_ff  <= nxt_mcc;
      trim_ff <= nxt_trim;
    end
  end

  // Source ticks: trimmed RC divider, sampled external clock, PLL
  assign rc_tick  = (rc_cnt_ff == 8'h00);
  assign ext_tick = ext_clk_in & ~ext_d_ff;
  assign pll_tick = (pll_cnt_ff == 5'h00);
  assign base_tick = opt_rc_en_in ? rc_tick : ext_tick;

  always_comb begin
    nxt_rc_cnt  = rc_tick ? rc_period(trim_ff) - 8'h01
                          : rc_cnt_ff - 8'h01;
    nxt_pll_cnt = pll_cnt_ff - 5'h01;
    if (pll_tick) begin
      nxt_pll_cnt = opt_pll_x8_in ? 5'(crm_pkg::PLL_X8_DIV - 1)
                                  : 5'(crm_pkg::PLL_X4_DIV - 1);
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rc_cnt_ff  <= 8'h00;
      pll_cnt_ff <= 5'h00;
      ext_d_ff   <= 1'b0;
    end else begin
      rc_cnt_ff  <= nxt_rc_cnt;
      pll_cnt_ff <= nxt_pll_cnt;
      ext_d_ff   <= ext_clk_in;
    end
  end

  // PLL startup: restarts with each reset or wakeup; lock follows it
  always_comb begin
    nxt_start  = start_ff;
    nxt_locked = locked_ff;
    if (!opt_pll_en_in || rif.seq_active || halt_wakeup_in) begin
      nxt_start  = 32'h0000_0000;
      nxt_locked = 1'b0;
    end else if (start_ff < PLL_STARTUP_CYC) begin
      nxt_start = start_ff + 32'h0000_0001;
    end else begin
      nxt_locked = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      start_ff  <= 32'h0000_0000;
      locked_ff <= 1'b0;
    end else begin
      start_ff  <= nxt_start;
      locked_ff <= nxt_locked;
    end
  end

  // Oscillator clock choice; the PLL gives no clock until locked
  always_comb begin
    if (opt_pll_en_in) osc_tick = pll_tick & locked_ff;
    else if (opt_rc_en_in) osc_tick = rc_tick;
    else osc_tick = ext_tick;
  end

  // Slow mode divides oscillator ticks by 32
  assign cpu_tick = mcc_ff[crm_pkg::BIT_SLOW_MODE]
                    ? (osc_tick && slow_ff == crm_pkg::SLOW_DIV_LAST)
                    : osc_tick;

  always_comb begin
    nxt_slow = osc_tick ? slow_ff + 5'h01 : slow_ff;
    nxt_mco  = mco_ff;
    if (!mcc_ff[crm_pkg::BIT_CLK_OUT]) nxt_mco = 1'b0;
    else if (osc_tick) nxt_mco = ~mco_ff;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      slow_ff <= 5'h00;
      mco_ff  <= 1'b0;
    end else begin
      slow_ff <= nxt_slow;
      mco_ff  <= nxt_mco;
    end
  end

  // Reset sequencer hookup
  assign rif.base_tick = base_tick;
  assign rif.cpu_tick  = cpu_tick;
  assign rif.pll_need  = opt_pll_en_in;
  assign rif.pll_ready = locked_ff;
  assign rif.low_voltage_detector       = low_voltage_detector_in;
  assign rif.wdg       = wdg_underflow_in;
  assign rif.pin_in    = rst_pin_in;

  crm_reset_seq #(
    .WDG_PULSE_CYC (WDG_PULSE_CYC)
  ) u_seq (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .rif       (rif)
  );

  // Outputs; pin is open-drain so its data is always low
  assign rst_pin_out             = 1'b0;
  assign rst_pin_oe_out          = rif.pin_oe;
  assign osc_tick_out            = osc_tick;
  assign cpu_tick_out            = cpu_tick;
  assign rc_trim_value_out       = trim_ff;
  assign clock_output_pin_out    = mco_ff;
  assign clock_output_enable_out = mcc_ff[crm_pkg::BIT_CLK_OUT];
  assign pll_locked_out          = locked_ff;
  assign core_rst_n_out          = rif.core_rst_n;
  assign vector_fetch_out        = rif.fetch;
  assign vector_addr_out         = rif.fetch_addr;

  // Checks on the clock side
  a_trim_default: assert property (@(posedge clk_in) disable iff
    (!arst_n_in) !rif.core_rst_n |=> trim_ff == 8'hFF)
    else $error("trim not restored on reset");
  a_slow_gap: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (cpu_tick && mcc_ff[0]) |-> slow_ff == 5'h1F)
    else $error("slow tick off the divide by 32");
  a_mco_gate: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !mcc_ff[1] |=> !mco_ff)
    else $error("clock output runs while disabled");
  a_lock_start: assert property (@(posedge clk_in) disable iff
    (!arst_n_in) $rose(locked_ff) |-> start_ff == PLL_STARTUP_CYC &&
    $past(opt_pll_en_in))
    else $error("lock without full startup");
  a_pll_gate: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (opt_pll_en_in && !locked_ff) |-> !osc_tick)
    else $error("PLL clock before startup");
  a_bus_wait: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (req && !ack_ff) |=> !(avs_read_in || avs_write_in) ||
    !avs_waitrequest_out)
    else $error("waitrequest held too long");
endmodule // crm_top

// ---- testbench/crm_partner.sv ----
/*
  Far side model: reset pin with weak pull-up, external reset circuit
  and a free-running external clock source.
  Assumes clk_in is the 100 MHz system clock.
*/
`timescale 1ns/1ps
module crm_partner #(
  parameter int unsigned EXT_HALF = 2
) (
  // System clock
  input  wire logic clk_in,
  // Reset pin
  input  wire logic rst_pin_oe_in,
  input  wire logic pull_low_in,
  output logic      rst_pin_out,
  // External clock
  output logic      ext_clk_out
);
  int unsigned half_cnt = 0;

  // Open drain: either party pulls low, otherwise the pull-up wins
  assign rst_pin_out = !(rst_pin_oe_in || pull_low_in);

  // Oscillator runs free; edges land just after the system edge
  initial begin
    ext_clk_out = 1'h0;
  end
  always @(posedge clk_in) begin
    half_cnt <= (half_cnt == EXT_HALF - 1) ? 0 : half_cnt + 1;
    if (half_cnt == EXT_HALF - 1) begin
      ext_clk_out <= !ext_clk_out;
    end
  end
endmodule // crm_partner

// ---- testbench/test_clock_reset_manager.sv ----
/*
  Self-checking bench for the clock and reset manager top.
  Assumes the partner model resolves the reset pin and makes the
  external clock; small PLL startup count keeps the run short.
*/
`timescale 1ns/1ps
module test_clock_reset_manager;
  localparam int unsigned PLL_ST = 20;
  localparam int unsigned WDG_PC = 4;
  localparam int unsigned EXT_PER = 4;
  localparam logic [7:0] TRIMS [4] = '{8'h00, 8'h80, 8'hFF, 8'h5B};
  // Design ports
  logic        clk_in, arst_n_in, avs_read_in, avs_write_in;
  logic [9:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [3:0]  avs_byteenable_in;
  logic        avs_waitrequest_out, opt_rc_en_in, opt_pll_en_in;
  logic        opt_pll_x8_in, ext_clk_in, halt_wakeup_in, pull_low;
  logic        low_voltage_detector_in, wdg_underflow_in, rst_pin_in;
  logic        rst_pin_out, rst_pin_oe_out, osc_tick_out, cpu_tick_out;
  logic        clock_output_pin_out, clock_output_enable_out;
  logic        pll_locked_out, core_rst_n_out, vector_fetch_out;
  logic [7:0]  rc_trim_value_out;
  logic [15:0] vector_addr_out;
  int          miscompares, check_count;

  crm_top #(.PLL_STARTUP_CYC(PLL_ST), .WDG_PULSE_CYC(WDG_PC)) i_crm_top (
    .clk_in, .arst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .opt_rc_en_in, .opt_pll_en_in, .opt_pll_x8_in,
    .ext_clk_in, .halt_wakeup_in, .low_voltage_detector_in,
    .wdg_underflow_in, .rst_pin_in, .rst_pin_out, .rst_pin_oe_out,
    .osc_tick_out, .cpu_tick_out, .rc_trim_value_out,
    .clock_output_pin_out, .clock_output_enable_out, .pll_locked_out,
    .core_rst_n_out, .vector_fetch_out, .vector_addr_out);

  crm_partner #(.EXT_HALF(EXT_PER / 2)) i_crm_partner (
    .clk_in, .rst_pin_oe_in(rst_pin_oe_out), .pull_low_in(pull_low),
    .rst_pin_out(rst_pin_in), .ext_clk_out(ext_clk_in));

  // 100 MHz clock
  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = !clk_in;
  end

  // Expected RC period in system cycles
  function automatic int rc_per(input logic [7:0] v);
    return 36 + int'(v) / 2;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One bus transfer; request held until the edge that sees waitrequest
  // low, read data taken at that edge; only the watchdog ends a hang
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, input logic [3:0] be,
                     output logic [31:0] rd);
    @(posedge clk_in);
    avs_address_in    <= {idx, 2'h0};
    avs_writedata_in  <= {24'h000000, wd};
    avs_byteenable_in <= be;
    avs_read_in       <= !wr;
    avs_write_in      <= wr;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'h0);
    rd = avs_readdata_out;
    avs_read_in  <= 1'h0;
    avs_write_in <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'h1, idx, d, 4'hF, r);
  endtask

  // Upper bytes of every word must read zero
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] r;
    bus(1'h0, idx, 8'h00, 4'hF, r);
    check(r, {24'h000000, e});
  endtask

  // Period of the oscillator tick; first two spans may be partial
  task automatic period(output int p);
    repeat (3) begin
      p = 0;
      do begin
        @(negedge clk_in);
        p++;
      end while (osc_tick_out !== 1'h1 && p < 1000);
    end
  endtask

  // CPU ticks seen over 64 oscillator ticks
  task automatic cpu_count(output int c);
    int o;
    o = 0;
    c = 0;
    while (o < 64) begin
      @(negedge clk_in);
      o += int'(osc_tick_out === 1'h1);
      c += int'(cpu_tick_out === 1'h1);
    end
  endtask

  task automatic clk_out(input logic en);
    logic b;
    repeat (6) begin
      do @(negedge clk_in); while (osc_tick_out !== 1'h1);
      b = clock_output_pin_out;
      @(negedge clk_in);
      check(clock_output_pin_out, en ? !b : 1'h0);
    end
  endtask

  // Follows delay, optional PLL wait and vector fetch to the end
  task automatic boot(input logic pll);
    int n;
    int t;
    logic ep;
    logic hi;
    n = 0;
    t = 0;
    ep = ext_clk_in;
    hi = 1'h0;
    while (vector_fetch_out !== 1'h1 && n < 5000) begin
      @(negedge clk_in);
      if (rst_pin_oe_out === 1'h1 && ext_clk_in && !ep) begin
        t++;
      end
      ep = ext_clk_in;
      n++;
    end
    check(32'(t >= 255 && t <= 257), 32'h1);
    check(rst_pin_oe_out, 1'h0);
    check(pll_locked_out, pll);
    check(vector_addr_out, crm_pkg::RESET_VECTOR);
    t = 0;
    while (vector_fetch_out === 1'h1 && n < 5000) begin
      t += int'(cpu_tick_out === 1'h1);
      hi |= vector_addr_out === 16'hFFFF;
      @(negedge clk_in);
      n++;
    end
    check(t, 2);
    check(hi, 1'h1);
    check(core_rst_n_out, 1'h1);
    check(rst_pin_out, 1'h0);
  endtask

  // Watchdog against a hung wait
  initial begin
    #500000;
    miscompares++;
    end_of_test;
  end

  initial begin
    logic [7:0] v;
    logic [31:0] r;
    int p;
    {arst_n_in, avs_read_in, avs_write_in, pull_low} = 4'h0;
    {opt_rc_en_in, opt_pll_en_in, opt_pll_x8_in} = 3'h0;
    {halt_wakeup_in, low_voltage_detector_in, wdg_underflow_in} = 3'h0;
    avs_address_in = 10'h000;
    avs_writedata_in = 32'h00000000;
    avs_byteenable_in = 4'hF;
    miscompares = 0;
    check_count = 0;
    void'($urandom(50));
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'h1;
    boot(1'h0);
    rd_chk(crm_pkg::IDX_MAIN_CLK, crm_pkg::RST_MAIN_CLK);
    rd_chk(crm_pkg::IDX_RC_TRIM, crm_pkg::RST_RC_TRIM);
    rd_chk(crm_pkg::IDX_SYS_INTEG, 8'h00);
    // Random trim traffic, refused writes, unmapped and read-only places
    for (int i = 0; i < 10; i++) begin
      v = 8'($urandom);
      wr(crm_pkg::IDX_RC_TRIM, v);
      rd_chk(crm_pkg::IDX_RC_TRIM, v);
      check(rc_trim_value_out, v);
    end
    wr(crm_pkg::IDX_RC_TRIM, 8'h3C);
    bus(1'h1, crm_pkg::IDX_RC_TRIM, 8'hC3, 4'hE, r);
    rd_chk(crm_pkg::IDX_RC_TRIM, 8'h3C);
    wr(8'h3B, 8'hA5);
    rd_chk(8'h3B, 8'h00);
    wr(crm_pkg::IDX_SYS_INTEG, 8'hFF);
    rd_chk(crm_pkg::IDX_SYS_INTEG, 8'h00);
    // RC source follows trim inversely, external source when RC is off
    opt_rc_en_in <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      v = (i == 3) ? 8'($urandom) : TRIMS[i];
      wr(crm_pkg::IDX_RC_TRIM, v);
      period(p);
      check(p, rc_per(v));
    end
    opt_rc_en_in <= 1'h0;
    period(p);
    check(p, EXT_PER);
    // Slow mode and clock output, all four settings
    for (int m = 0; m < 4; m++) begin
      wr(crm_pkg::IDX_MAIN_CLK, 8'(m));
      rd_chk(crm_pkg::IDX_MAIN_CLK, 8'(m));
      check(clock_output_enable_out, m[1]);
      cpu_count(p);
      check(p, m[0] ? 2 : 64);
      clk_out(m[1]);
    end
    // Low voltage, watchdog and external pin resets
    for (int s = 0; s < 3; s++) begin
      wr(crm_pkg::IDX_RC_TRIM, 8'h5A);
      wr(crm_pkg::IDX_MAIN_CLK, 8'h03);
      @(posedge clk_in);
      case (s)
        0: low_voltage_detector_in <= 1'h1;
        1: wdg_underflow_in <= 1'h1;
        default: pull_low <= 1'h1;
      endcase
      #1;
      if (s == 2) begin
        check(core_rst_n_out, 1'h0);
      end
      @(posedge clk_in);
      wdg_underflow_in <= 1'h0;
      repeat (WDG_PC) begin
        @(negedge clk_in);
        check(rst_pin_in, 1'h0);
        check(core_rst_n_out, 1'h0);
      end
      @(posedge clk_in);
      low_voltage_detector_in <= 1'h0;
      pull_low <= 1'h0;
      boot(1'h0);
      rd_chk(crm_pkg::IDX_RC_TRIM, crm_pkg::RST_RC_TRIM);
      rd_chk(crm_pkg::IDX_MAIN_CLK, crm_pkg::RST_MAIN_CLK);
    end
    // PLL x4 and x8 behind a reset, then a wakeup restart
    for (int x = 0; x < 2; x++) begin
      @(posedge clk_in);
      opt_pll_en_in <= 1'h1;
      opt_pll_x8_in <= x[0];
      low_voltage_detector_in <= 1'h1;
      repeat (2) @(posedge clk_in);
      low_voltage_detector_in <= 1'h0;
      boot(1'h1);
      rd_chk(crm_pkg::IDX_SYS_INTEG, 8'h08);
      period(p);
      check(p, x ? crm_pkg::PLL_X8_DIV : crm_pkg::PLL_X4_DIV);
    end
    @(posedge clk_in);
    halt_wakeup_in <= 1'h1;
    @(posedge clk_in);
    halt_wakeup_in <= 1'h0;
    @(negedge clk_in);
    check(pll_locked_out, 1'h0);
    p = 0;
    while (pll_locked_out !== 1'h1 && p < 100) begin
      @(negedge clk_in);
      p++;
    end
    check(32'(p >= PLL_ST - 3 && p <= PLL_ST + 3), 32'h1);
    end_of_test;
  end
endmodule // test_clock_reset_manager
